// >>> design/pport_map.svh
// register offsets, field positions, reset values and timing for the printer port
`ifndef PPORT_MAP_SVH
`define PPORT_MAP_SVH
`define PP_OFS_DATA 3'h0
`define PP_OFS_STAT 3'h1
`define PP_OFS_CTL 3'h2
`define PP_OFS_EADDR 3'h3
`define PP_OFS_EDATA3 3'h7
`define PP_RST_BYTE 8'h00
`define PP_RST_CTL 6'h00
`define PP_ST_EXPIRY 0
`define PP_CT_STROBE 0
`define PP_CT_LF 1
`define PP_CT_INIT 2
`define PP_CT_SEL 3
`define PP_CT_IRQ 4
`define PP_CT_DIR 5
`define PP_CT_W 6
`define PP_EXPIRY_NS 10000
`define PP_CLK_NS 25
`define PP_BASE 16'h0378
`define PP_FIFO_DEPTH 16
`define PP_RST_SYNC 5'h08
`define PP_SYNC_LAG 16'h0002
`endif

// >>> design/pport_pkg.sv
// types shared by the printer port design
package pport_pkg;
    typedef enum logic [0:0] {
        EPP_IDLE = 1'b0,
        EPP_BUSY = 1'b1
    } epp_state_e;
    typedef logic [7:0] byte_t;
endpackage

// >>> design/pport_regs.sv
// printer port host registers, enhanced cycle engine and write buffer
`timescale 1ns/1ps
`include "pport_map.svh"

// ==========================================================
// write buffer
module pp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = `PP_FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_chk
        $error("fifo depth must be a power of two of at least 2");
    end

    assign in_ready_o = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
    assign out_valid_o = (wr_q != rd_q);
    assign out_data_o = mem_q[rd_q[AW-1:0]];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i)
    begin
        if (ce_i && push)
        begin
            mem_q[wr_q[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else if (ce_i)
        begin
            if (push)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

// ==========================================================
// port top
module pport_regs #(
    parameter logic [15:0] BASE_ADDR = `PP_BASE,
    parameter int FIFO_DEPTH = `PP_FIFO_DEPTH,
    parameter int EXPIRY_CYC = `PP_EXPIRY_NS / `PP_CLK_NS
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [15:0] host_addr_i,
    input wire pport_pkg::byte_t host_wdata_i,
    input wire logic host_write_strobe_n_i,
    input wire logic host_read_strobe_n_i,
    output pport_pkg::byte_t host_rdata_o,
    output logic host_rdata_oe_o,
    output logic host_ready_o,
    input wire logic extended_mode_i,
    input wire logic enhanced_cycle_mode_i,
    input wire pport_pkg::byte_t port_data_lines_i,
    output pport_pkg::byte_t port_data_lines_o,
    output logic port_data_lines_oe_o,
    input wire logic fault_input_i,
    input wire logic printer_online_i,
    input wire logic media_exhausted_i,
    input wire logic char_taken_input_i,
    input wire logic peripheral_occupied_i,
    output logic data_valid_out_n_o,
    output logic line_feed_out_n_o,
    output logic printer_reset_line_o,
    output logic select_request_out_n_o,
    output logic epp_addr_strobe_n_o,
    output logic epp_data_strobe_n_o,
    output logic irq_o
);
    import pport_pkg::*;

    if (EXPIRY_CYC < 4 || EXPIRY_CYC > 65536 || FIFO_DEPTH < 2)
    begin : g_chk
        $error("expiry count must lie in 4..65536 and fifo depth be at least 2");
    end

    function automatic logic hit(input logic [15:0] a);
        hit = (a[15:3] == BASE_ADDR[15:3]);
    endfunction

    // ======================================================
    // strobes and decode
    logic wr_n_q;
    logic rd_n_q;
    logic [4:0] st_s1_q;
    logic [4:0] st_s2_q;
    logic ack_prev_q;
    byte_t data_q;
    logic [`PP_CT_W-1:0] ctl_q;
    logic expiry_q;
    byte_t rdata_q;
    epp_state_e state_q;
    logic [15:0] cnt_q;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [8:0] fifo_out;
    logic wr_edge;
    logic rd_edge;
    logic [2:0] ofs;
    logic win;
    logic done;
    logic expire;
    logic launch;

    assign ofs = host_addr_i[2:0];
    assign wr_edge = ce_i && !wr_n_q && host_write_strobe_n_i && hit(host_addr_i);
    assign rd_edge = ce_i && rd_n_q && !host_read_strobe_n_i && hit(host_addr_i);
    assign win = enhanced_cycle_mode_i && (ofs >= `PP_OFS_EADDR);

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
        end
        else if (ce_i)
        begin
            wr_n_q <= host_write_strobe_n_i;
            rd_n_q <= host_read_strobe_n_i;
        end
    end

    // status inputs: {busy, ack, paper, online, fault}
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            // acknowledge idles high: start high so reset gives no false edge
            st_s1_q <= `PP_RST_SYNC;
            st_s2_q <= `PP_RST_SYNC;
            ack_prev_q <= 1'b1;
        end
        else if (ce_i)
        begin
            st_s1_q <= {peripheral_occupied_i, char_taken_input_i, media_exhausted_i,
                        printer_online_i, fault_input_i};
            st_s2_q <= st_s1_q;
            ack_prev_q <= st_s2_q[3];
        end
    end

    // ======================================================
    // data and control registers
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            data_q <= `PP_RST_BYTE;
            ctl_q <= `PP_RST_CTL;
        end
        else if (wr_edge && ofs == `PP_OFS_DATA)
        begin
            data_q <= host_wdata_i;
        end
        else if (wr_edge && ofs == `PP_OFS_CTL)
        begin
            ctl_q <= host_wdata_i[`PP_CT_W-1:0];
        end
    end

    // ======================================================
    // enhanced cycle engine
    // the synced wait level lags the strobe, so a stale high must not end a cycle
    assign done = (state_q == EPP_BUSY) && st_s2_q[4] && (cnt_q >= `PP_SYNC_LAG);
    assign launch = (state_q == EPP_IDLE) && fifo_out_valid;
    assign expire = (state_q == EPP_BUSY) && !st_s2_q[4]
        && (cnt_q == 16'(EXPIRY_CYC - 1));

    pp_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .in_valid_i(wr_edge && win),
        .in_ready_o(fifo_in_ready),
        .in_data_i({ofs == `PP_OFS_EADDR, host_wdata_i}),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(ce_i && (done || expire)),
        .out_data_o(fifo_out)
    );

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_q <= EPP_IDLE;
            cnt_q <= 16'h0000;
            epp_addr_strobe_n_o <= 1'b1;
            epp_data_strobe_n_o <= 1'b1;
        end
        else if (ce_i)
        begin
            case (state_q)
                EPP_IDLE:
                begin
                    cnt_q <= 16'h0000;
                    if (fifo_out_valid)
                    begin
                        state_q <= EPP_BUSY;
                        epp_addr_strobe_n_o <= !fifo_out[8];
                        epp_data_strobe_n_o <= fifo_out[8];
                    end
                end
                EPP_BUSY:
                begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (done || expire)
                    begin
                        state_q <= EPP_IDLE;
                        epp_addr_strobe_n_o <= 1'b1;
                        epp_data_strobe_n_o <= 1'b1;
                    end
                end
                default:
                begin
                    state_q <= EPP_IDLE;
                end
            endcase
        end
    end

    // expiry flag: a new expiry wins over a clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            expiry_q <= 1'b0;
        end
        else if (ce_i && expire)
        begin
            expiry_q <= 1'b1;
        end
        else if (wr_edge && ofs == `PP_OFS_STAT && enhanced_cycle_mode_i
                 && host_wdata_i[`PP_ST_EXPIRY])
        begin
            expiry_q <= 1'b0;
        end
    end

    // ======================================================
    // host read path
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rdata_q <= `PP_RST_BYTE;
            host_rdata_oe_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (host_read_strobe_n_i)
            begin
                host_rdata_oe_o <= 1'b0;
            end
            else if (rd_edge)
            begin
                host_rdata_oe_o <= 1'b1;
                case (ofs)
                    `PP_OFS_DATA: rdata_q <= port_data_lines_i;
                    `PP_OFS_STAT: rdata_q <= {!st_s2_q[4], st_s2_q[3:0], 2'b00,
                                              expiry_q};
                    `PP_OFS_CTL: rdata_q <= {2'b00, ctl_q};
                    default: rdata_q <= win ? port_data_lines_i : `PP_RST_BYTE;
                endcase
            end
        end
    end
    assign host_rdata_o = rdata_q;
    // status bits 3..7 carry fault, online, paper, ack, ~busy

    // ======================================================
    // port outputs
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            data_valid_out_n_o <= 1'b1;
            line_feed_out_n_o <= 1'b1;
            printer_reset_line_o <= 1'b0;
            select_request_out_n_o <= 1'b1;
            port_data_lines_o <= `PP_RST_BYTE;
            port_data_lines_oe_o <= 1'b1;
            host_ready_o <= 1'b1;
            irq_o <= 1'b0;
        end
        else if (ce_i)
        begin
            data_valid_out_n_o <= !ctl_q[`PP_CT_STROBE];
            line_feed_out_n_o <= !ctl_q[`PP_CT_LF];
            printer_reset_line_o <= ctl_q[`PP_CT_INIT];
            select_request_out_n_o <= !ctl_q[`PP_CT_SEL];
            port_data_lines_o <= (state_q == EPP_BUSY || launch)
                ? fifo_out[7:0] : data_q;
            port_data_lines_oe_o <= (state_q == EPP_BUSY) || launch
                || !(extended_mode_i && ctl_q[`PP_CT_DIR]);
            host_ready_o <= fifo_in_ready;
            if (ctl_q[`PP_CT_IRQ] && st_s2_q[3] && !ack_prev_q)
            begin
                irq_o <= 1'b1;
            end
            else if (!ctl_q[`PP_CT_IRQ] || rd_edge)
            begin
                irq_o <= 1'b0;
            end
        end
    end

    // ======================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    property p_data_cap;
        (wr_edge && ofs == `PP_OFS_DATA) ##1 (ce_i && state_q == EPP_IDLE && !launch)
            |=> port_data_lines_o == $past(host_wdata_i, 2);
    endproperty
    a_data_cap: assert property (p_data_cap) else $error("data byte not driven");
    property p_rd_hold;
        host_rdata_oe_o && !host_read_strobe_n_i |=> $stable(host_rdata_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("status changed in read");
    property p_clr;
        wr_edge && ofs == `PP_OFS_STAT && enhanced_cycle_mode_i && host_wdata_i[0] && !expire
            |=> !expiry_q;
    endproperty
    a_clr: assert property (p_clr) else $error("expiry flag not cleared");
    property p_zero;
        rd_edge && ofs == `PP_OFS_STAT |=> host_rdata_o[2:1] == 2'b00 && host_rdata_oe_o;
    endproperty
    a_zero: assert property (p_zero) else $error("status bits 1,2 not zero");
    property p_ctl_hi;
        rd_edge && ofs == `PP_OFS_CTL |=> host_rdata_o == {2'b00, $past(ctl_q)};
    endproperty
    a_ctl_hi: assert property (p_ctl_hi) else $error("control read wrong");
    property p_strobe;
        ce_i |=> data_valid_out_n_o == !$past(ctl_q[`PP_CT_STROBE]);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe not inverted");
    property p_expiry;
        state_q == EPP_BUSY |-> cnt_q < 16'(EXPIRY_CYC);
    endproperty
    a_expiry: assert property (p_expiry) else $error("cycle outlived expiry");
    property p_irq;
        ce_i && ctl_q[`PP_CT_IRQ] && st_s2_q[3] && !ack_prev_q |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missed");
    property p_dir;
        ce_i && !extended_mode_i |=> port_data_lines_oe_o;
    endproperty
    a_dir: assert property (p_dir) else $error("lines not driven outward");
    c_expire: cover property (expire ##1 expiry_q);
    c_done: cover property (state_q == EPP_BUSY ##[1:20] done);
    c_irq: cover property ($rose(irq_o));
endmodule

// >>> verification/pp_printer.sv
// printer side model: status levels, wait handshake and released data lines
`timescale 1ns/1ps
module pp_printer (
    input wire logic clk_i,
    input wire logic stall_i,
    input wire logic [4:0] lvl_i,
    input wire logic [7:0] drv_i,
    input wire logic drv_oe_i,
    input wire logic addr_strobe_n_i,
    input wire logic data_strobe_n_i,
    output logic [7:0] data_o,
    output logic busy_o,
    output logic [3:0] st_o
);
    logic [7:0] last_q;
    // ========================================
    // data lines: released lines show the inverse of the last driven byte
    always_ff @(posedge clk_i)
    begin
        if (drv_oe_i)
        begin
            last_q <= drv_i;
        end
    end
    assign data_o = drv_oe_i ? drv_i : ~last_q;
    // ========================================
    // wait line held low while stalling an enhanced cycle, high in an unstalled cycle, else busy level
    assign busy_o = (!addr_strobe_n_i || !data_strobe_n_i) ? !stall_i : lvl_i[4];
    assign st_o = lvl_i[3:0];
endmodule

// >>> verification/printer_port_register_interface_tb.sv
// self-checking bench for the printer port host registers
`timescale 1ns/1ps
module printer_port_register_interface_tb;
    import pport_pkg::*;
    localparam logic [15:0] A = 16'h0378;
    logic clk = 1'b0, srst = 1'b1, wr_n = 1'b1, rd_n = 1'b1, ext = 1'b0, enh = 1'b0;
    logic stall = 1'b0, rdy, oe, roe, irq, ds_n, lf_n, init, sel_n, as_n, es_n, busy, o;
    logic ce = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [4:0] lvl = 5'h00;
    logic [3:0] st;
    byte_t wdata = 8'h00, rdata, lo, li, d, seen_addr, seen_data;
    int miscompares = 0, comparisons = 0, low_cnt = 0;
    always #12.5 clk = ~clk;
    pport_regs #(.EXPIRY_CYC(8)) dut_u (.clk_i(clk), .srst_i(srst), .ce_i(ce),
        .host_addr_i(addr), .host_wdata_i(wdata), .host_write_strobe_n_i(wr_n),
        .host_read_strobe_n_i(rd_n), .host_rdata_o(rdata), .host_rdata_oe_o(roe),
        .host_ready_o(rdy), .extended_mode_i(ext), .enhanced_cycle_mode_i(enh),
        .port_data_lines_i(li), .port_data_lines_o(lo), .port_data_lines_oe_o(oe),
        .fault_input_i(st[0]), .printer_online_i(st[1]), .media_exhausted_i(st[2]),
        .char_taken_input_i(st[3]), .peripheral_occupied_i(busy),
        .data_valid_out_n_o(ds_n), .line_feed_out_n_o(lf_n), .printer_reset_line_o(init),
        .select_request_out_n_o(sel_n), .epp_addr_strobe_n_o(as_n),
        .epp_data_strobe_n_o(es_n), .irq_o(irq));
    pp_printer peer_u (.clk_i(clk), .stall_i(stall), .lvl_i(lvl), .drv_i(lo), .drv_oe_i(oe),
        .addr_strobe_n_i(as_n), .data_strobe_n_i(es_n), .data_o(li), .busy_o(busy),
        .st_o(st));
    always @(posedge clk)
    begin
        if (!as_n)
            seen_addr <= lo;
        if (!es_n)
            seen_data <= lo;
        if (!rdy)
            low_cnt <= low_cnt + 1;
    end
    // ========================================
    // bus tasks and comparison
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input byte_t v);
        addr = a;
        wdata = v;
        wr_n = 1'b0;
        tick(1);
        wr_n = 1'b1;
        tick(3);
    endtask
    task automatic rd(input logic [15:0] a);
        addr = a;
        rd_n = 1'b0;
        tick(3);
        d = rdata;
        o = roe;
        rd_n = 1'b1;
        tick(2);
    endtask
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out;
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ========================================
    // scenarios
    task automatic t_reset;
        rd(A + 2);
        check("ctl reset", d, 8'h00);
        check("read oe", o, 8'h01);
        rd(A);
        check("data reset", d, 8'h00);
        check("pins reset", {ds_n, lf_n, init, sel_n, irq, oe}, 8'h35);
    endtask
    task automatic t_ctl;
        wr(A + 2, 8'hFF);
        rd(A + 2);
        check("ctl high bits", d, 8'h3F);
        check("ctl pins a", {ds_n, lf_n, init, sel_n}, 8'h02);
        wr(A + 2, 8'h05);
        rd(A + 2);
        check("ctl back", d, 8'h05);
        check("ctl pins b", {ds_n, lf_n, init, sel_n}, 8'h07);
        wr(A + 2, 8'h0A);
        check("ctl pins c", {ds_n, lf_n, init, sel_n}, 8'h08);
    endtask
    task automatic t_data;
        wr(A, 8'hA5);
        check("lines out", lo, 8'hA5);
        rd(A);
        check("data live", d, 8'hA5);
        ext = 1'b1;
        wr(A + 2, 8'h20);
        check("dir in", oe, 8'h00);
        rd(A);
        check("data input", d, 8'h5A);
        ext = 1'b0;
        tick(2);
        check("dir printer", oe, 8'h01);
        wr(A + 2, 8'h00);
    endtask
    task automatic t_freeze;
        ce = 1'b0;
        wr(A, 8'h3C);
        ce = 1'b1;
        tick(2);
        check("frozen data", lo, 8'hA5);
    endtask
    task automatic t_status;
        for (int i = 0; i < 32; i++)
        begin
            lvl = i[4:0];
            tick(4);
            rd(A + 1);
            check("status", d, {~lvl[4], lvl[3:0], 3'b000});
        end
        lvl = 5'h00;
    endtask
    task automatic t_windows;
        for (int i = 3; i < 8; i++)
        begin
            wr(A + i[15:0], 8'hC3);
            rd(A + i[15:0]);
            check("window off", d, 8'h00);
        end
        check("no cycle", {as_n, es_n}, 8'h03);
        rd(16'h0278);
        check("unmapped oe", o, 8'h00);
    endtask
    task automatic t_expiry;
        enh = 1'b1;
        stall = 1'b0;
        wr(A + 3, 8'h81);
        tick(10);
        check("addr cycle", seen_addr, 8'h81);
        rd(A + 1);
        check("no expiry", d[0], 8'h00);
        stall = 1'b1;
        wr(A + 4, 8'h3C);
        tick(20);
        check("data cycle", seen_data, 8'h3C);
        rd(A + 1);
        check("expiry set", d[0], 8'h01);
        wr(A + 1, 8'h00);
        rd(A + 1);
        check("write zero", d[0], 8'h01);
        wr(A + 1, 8'h01);
        rd(A + 1);
        check("write one", d[0], 8'h00);
        wr(A + 4, 8'h3C);
        tick(20);
        enh = 1'b0;
        wr(A + 1, 8'h01);
        rd(A + 1);
        check("status ro", d[0], 8'h01);
        enh = 1'b1;
        wr(A + 1, 8'h01);
        stall = 1'b0;
    endtask
    task automatic t_fifo;
        int base;
        base = low_cnt;
        stall = 1'b1;
        repeat (40) wr(A + 5, 8'h11);
        check("buffer full", low_cnt > base, 8'h01);
        stall = 1'b0;
        tick(300);
        check("buffer drained", rdy, 8'h01);
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        tick(1);
        rd(A + 1);
        check("flag reset", d[0], 8'h00);
        rd(A + 2);
        check("ctl reset again", d, 8'h00);
        enh = 1'b0;
    endtask
    task automatic t_irq;
        wr(A + 2, 8'h10);
        lvl[3] = 1'b1;
        tick(8);
        check("irq set", irq, 8'h01);
        rd(A + 1);
        check("irq read clear", irq, 8'h00);
        wr(A + 2, 8'h00);
        lvl[3] = 1'b0;
        tick(4);
        lvl[3] = 1'b1;
        tick(8);
        check("irq gated", irq, 8'h00);
    endtask
    // ========================================
    // main sequence and watchdog
    initial
    begin
        tick(2);
        srst = 1'b0;
        tick(1);
        t_reset();
        t_ctl();
        t_data();
        t_freeze();
        t_status();
        t_windows();
        t_expiry();
        t_fifo();
        t_irq();
        close_out();
    end
    initial
    begin
        #(25 * 20000);
        miscompares++;
        close_out();
    end
endmodule
